// [smc_device.sv]
// Sleep-mode controller: the device end of the link.
// Assumes the CPU side pulses halt for one cycle per halt instruction.
module smc_device
	import smc_pkg::*;
(
	input  wire logic       i_clock,                // System clock.
	input  wire logic       i_srst,                 // Synchronous reset.
	smc_if.dev              link,                   // CPU-side link.
	input  wire logic [3:0] i_clock_source_fuses,   // Clock source fuses.
	input  wire logic [2:0] i_brownout_level_fuses, // Brown-out fuses.
	input  wire logic       i_xtal_selected,        // Crystal clock option.
	input  wire logic       i_comparator_off,       // Comparator disable bit.
	input  wire logic       i_comparator_uses_ref,  // Comparator on reference.
	input  wire logic       i_watchdog_enable,      // Watchdog enabled.
	input  wire logic [7:0] i_wake_pin_mask,        // Pins needed for wake.
	output logic            o_cpu_clk_en,           // CPU clock gate.
	output logic            o_flash_clk_en,         // Flash clock gate.
	output logic            o_io_clk_en,            // I/O clock gate.
	output logic            o_osc_en,               // Oscillator enable.
	output logic            o_comparator_en,        // Comparator power.
	output logic            o_bod_en,               // Brown-out detector on.
	output logic            o_ref_en,               // Reference enable.
	output logic            o_ref_ready,            // Reference settled.
	output logic            o_watchdog_run,         // Watchdog running.
	output logic [7:0]      o_input_buf_en          // Digital input buffers.
);
	// ==========================================================
	// Registers and state.
	logic [7:0]     ctl_q;
	logic [7:0]     ibd_q;
	smc_dev_state_t state_q;
	smc_mode_t      mode_q;
	logic [15:0]    cnt_q;
	logic [15:0]    ref_cnt_q;
	logic           ref_en_q;
	logic           done_q;
	logic           resume_q;
	logic           rstw_q;
	smc_mode_t      sel_mode;
	logic           cmp_on;
	logic           wake_idle;
	logic           wake_deep;
	logic           ref_need;
	logic [15:0]    pd_cyc;

	assign link.rd_ctl     = ctl_q;
	assign link.rd_ibd     = ibd_q;
	assign link.halt_done  = done_q;
	assign link.irq_resume = resume_q;
	assign link.reset_wake = rstw_q;
	assign link.asleep     = (state_q != DEV_ACTIVE);

	// Decode the mode; 10 falls back to Power-down without a crystal.
	always_comb begin
		unique case ({ctl_q[BIT_SELECT_HI], ctl_q[BIT_SELECT_LO]})
			2'b00: sel_mode = MODE_IDLE; // R2
			2'b10: sel_mode = i_xtal_selected ? MODE_STANDBY : MODE_PDOWN; // R14
			default: sel_mode = MODE_PDOWN; // R2
		endcase
	end

	// Power-down restart delay follows the clock source selection.
	assign pd_cyc = (i_clock_source_fuses == FUSE_EXT_CLOCK ||
		i_clock_source_fuses == FUSE_LOW_OSC) ? PD_EXT_CYC : PD_XTAL_CYC; // R13

	// Comparator is powered only in active or Idle and not switched off.
	assign cmp_on = !i_comparator_off &&
		(state_q == DEV_ACTIVE || mode_q == MODE_IDLE); // R8 R17

	// Idle accepts every enabled interrupt; deep modes only async ones.
	assign wake_idle = (|link.irq_idle) || link.ext0_level || link.pin_change ||
		link.usi_start || (link.cmp_irq && cmp_on); // R7 R8
	assign wake_deep = link.ext0_level || link.pin_change || link.usi_start; // R10

	// ==========================================================
	// Software-visible registers; a reset source clears them.
	always_ff @(posedge i_clock) begin
		if (i_srst || link.rst_req) begin
			ctl_q <= MCU_CONTROL_RST;
			ibd_q <= INPUT_BUF_RST;
		end else if (link.wr_en) begin
			if (link.wr_sel == SEL_INPUT_BUF) begin
				ibd_q <= link.wr_data; // R22
			end else begin
				ctl_q <= link.wr_data;
			end
		end
	end

	// ==========================================================
	// Sleep sequencer; CPU state is never touched so memories persist.
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			state_q <= DEV_ACTIVE;
			mode_q  <= MODE_IDLE;
			cnt_q   <= 16'h0000;
		end else if (link.rst_req) begin
			state_q <= DEV_ACTIVE; // R5
		end else begin
			unique case (state_q)
				DEV_ACTIVE: begin
					if (link.halt && ctl_q[BIT_SLEEP_ALLOW]) begin
						state_q <= DEV_SLEEP; // R1 R4
						mode_q  <= sel_mode;
					end
				end
				DEV_SLEEP: begin
					if (mode_q == MODE_IDLE && wake_idle) begin
						state_q <= DEV_HOLD;
						cnt_q   <= WAKE_HOLD_CYC - 16'h0001; // R3
					end else if (mode_q != MODE_IDLE && wake_deep) begin
						state_q <= DEV_START;
						cnt_q   <= (mode_q == MODE_STANDBY) ?
							STANDBY_CYC - 16'h0001 : pd_cyc - 16'h0001; // R13 R14
					end
				end
				DEV_START: begin
					if (cnt_q == 16'h0000) begin
						state_q <= DEV_HOLD;
						cnt_q   <= WAKE_HOLD_CYC - 16'h0001; // R3
					end else begin
						cnt_q <= cnt_q - 16'h0001;
					end
				end
				DEV_HOLD: begin
					if (cnt_q == 16'h0000) begin
						state_q <= DEV_ACTIVE; // R3 R4
					end else begin
						cnt_q <= cnt_q - 16'h0001;
					end
				end
			endcase
		end
	end

	// Completion pulses back to the CPU side.
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			done_q   <= 1'b0;
			resume_q <= 1'b0;
			rstw_q   <= 1'b0;
		end else begin
			done_q   <= !link.rst_req && state_q == DEV_ACTIVE &&
				link.halt && !ctl_q[BIT_SLEEP_ALLOW]; // R23
			resume_q <= !link.rst_req && state_q == DEV_HOLD &&
				cnt_q == 16'h0000; // R3
			rstw_q   <= link.rst_req && state_q != DEV_ACTIVE; // R5
		end
	end

	// ==========================================================
	// Clock gates, comparator and input buffers follow the sleeping mode; brown-out and watchdog follow their inputs.
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			o_cpu_clk_en    <= 1'b1;
			o_flash_clk_en  <= 1'b1;
			o_io_clk_en     <= 1'b1;
			o_osc_en        <= 1'b1;
			o_comparator_en <= 1'b0;
			o_bod_en        <= 1'b0;
			o_watchdog_run  <= 1'b0;
			o_input_buf_en  <= 8'h00;
		end else begin
			o_cpu_clk_en    <= (state_q == DEV_ACTIVE); // R6 R3
			o_flash_clk_en  <= (state_q == DEV_ACTIVE); // R6
			o_io_clk_en     <= (state_q == DEV_ACTIVE ||
				mode_q == MODE_IDLE); // R6 R9 R11
			o_osc_en        <= (state_q == DEV_ACTIVE) ||
				(state_q == DEV_SLEEP && mode_q != MODE_PDOWN) ||
				(state_q == DEV_HOLD); // R9 R14
			o_comparator_en <= cmp_on; // R17
			o_bod_en        <= (i_brownout_level_fuses != BOD_FUSES_OFF); // R18
			o_watchdog_run  <= i_watchdog_enable; // R19
			if (state_q == DEV_ACTIVE || mode_q == MODE_IDLE) begin
				o_input_buf_en <= ~ibd_q; // R22
			end else begin
				o_input_buf_en <= ~ibd_q & i_wake_pin_mask; // R21 R22
			end
		end
	end

	// ==========================================================
	// Reference runs for the detector or a comparator that uses it.
	assign ref_need = (i_brownout_level_fuses != BOD_FUSES_OFF) ||
		(!i_comparator_off && i_comparator_uses_ref); // R17 R20
	assign o_ref_en = ref_en_q;

	// Count the settling time after each switch-on.
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			ref_en_q    <= 1'b0;
			ref_cnt_q   <= 16'h0000;
			o_ref_ready <= 1'b0;
		end else begin
			ref_en_q <= ref_need; // R20
			if (!ref_en_q) begin
				ref_cnt_q   <= REF_START_CYC;
				o_ref_ready <= 1'b0;
			end else if (ref_cnt_q != 16'h0000) begin
				ref_cnt_q <= ref_cnt_q - 16'h0001; // R20
			end else begin
				o_ref_ready <= 1'b1;
			end
		end
	end
endmodule

// [smc_host.sv]
// CPU-side end: AHB-Lite registers drive the sleep sequence.
// Assumes a single AHB-Lite master at the same clock.
module smc_host
	import smc_pkg::*;
(
	input  wire logic        i_clock,     // System clock.
	input  wire logic        i_srst,      // Synchronous reset.
	smc_if.cpu               link,        // Device link.
	input  wire logic        i_hsel,      // Slave select.
	input  wire logic [31:0] i_haddr,     // Address.
	input  wire logic [1:0]  i_htrans,    // Transfer type.
	input  wire logic        i_hwrite,    // Write flag.
	input  wire logic [2:0]  i_hsize,     // Transfer size.
	input  wire logic [31:0] i_hwdata,    // Write data.
	input  wire logic        i_hready,    // Bus ready.
	output logic             o_hreadyout, // Always ready.
	output logic             o_hresp,     // Always OKAY.
	output logic [31:0]      o_hrdata     // Read data.
);
	smc_host_state_t state_q;
	logic [1:0]      mode_q;
	logic            go_q;
	logic [8:0]      wake_q;
	logic [7:0]      ibd_q;
	logic            ibd_pend_q;
	logic [1:0]      woke_q;
	logic            wr_en_q;
	logic            wr_sel_q;
	logic [7:0]      wr_data_q;
	logic            halt_q;
	logic            dp_wr_q;
	logic [7:0]      dp_addr_q;
	logic            addr_ok;

	assign o_hreadyout     = 1'b1;
	assign o_hresp         = 1'b0;
	assign addr_ok         = i_hsel && i_htrans[1] && i_hready;
	assign link.wr_en      = wr_en_q;
	assign link.wr_sel     = wr_sel_q;
	assign link.wr_data    = wr_data_q;
	assign link.halt       = halt_q;
	assign link.ext0_level = wake_q[0]; // R12
	assign link.pin_change = wake_q[1];
	assign link.usi_start  = wake_q[2];
	assign link.cmp_irq    = wake_q[3];
	assign link.irq_idle   = wake_q[7:4];
	assign link.rst_req    = wake_q[8];

	// ==========================================================
	// Bus slave: capture the address phase, then read or write.
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			dp_wr_q   <= 1'b0;
			dp_addr_q <= 8'h00;
			o_hrdata  <= 32'h0000_0000;
		end else begin
			dp_wr_q   <= addr_ok && i_hwrite;
			dp_addr_q <= i_haddr[7:0];
			if (addr_ok && !i_hwrite) begin
				unique case (i_haddr[7:0])
					OFS_CMD:     o_hrdata <= {30'h0, mode_q};
					OFS_STATUS:  o_hrdata <= {28'h0, woke_q, link.asleep,
						state_q != H_IDLE || go_q};
					OFS_WAKE:    o_hrdata <= {23'h0, wake_q};
					OFS_IBD:     o_hrdata <= {24'h0, link.rd_ibd};
					OFS_DEV_CTL: o_hrdata <= {24'h0, link.rd_ctl};
					default:     o_hrdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Software registers; wake levels stay until software clears them.
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			mode_q     <= 2'h0;
			wake_q     <= 9'h000;
			ibd_q      <= 8'h00;
			ibd_pend_q <= 1'b0;
		end else begin
			if (dp_wr_q && dp_addr_q == OFS_CMD) begin
				mode_q <= i_hwdata[1:0];
			end
			if (dp_wr_q && dp_addr_q == OFS_WAKE) begin
				wake_q <= i_hwdata[8:0]; // R12
			end
			if (dp_wr_q && dp_addr_q == OFS_IBD) begin
				ibd_q      <= i_hwdata[7:0];
				ibd_pend_q <= 1'b1;
			end else if (state_q == H_IDLE && !go_q) begin
				ibd_pend_q <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Sequence: arm, halt, wait for the outcome, disarm.
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			state_q   <= H_IDLE;
			go_q      <= 1'b0;
			woke_q    <= 2'h0;
			wr_en_q   <= 1'b0;
			wr_sel_q  <= SEL_MCU_CONTROL;
			wr_data_q <= 8'h00;
			halt_q    <= 1'b0;
		end else begin
			wr_en_q <= 1'b0;
			halt_q  <= 1'b0;
			unique case (state_q)
				H_IDLE: begin
					if (go_q) begin
						go_q      <= 1'b0;
						state_q   <= H_ARM;
						wr_en_q   <= 1'b1;
						wr_sel_q  <= SEL_MCU_CONTROL;
						wr_data_q <= {link.rd_ctl[7], mode_q[1], 1'b1,
							mode_q[0], link.rd_ctl[3:0]}; // R16 R15
					end else if (ibd_pend_q) begin
						wr_en_q   <= 1'b1;
						wr_sel_q  <= SEL_INPUT_BUF;
						wr_data_q <= ibd_q; // R22
					end
				end
				H_ARM: begin
					state_q <= H_HALT;
					halt_q  <= 1'b1; // R1
				end
				H_HALT: state_q <= H_WAIT;
				H_WAIT: begin
					if (link.reset_wake) begin
						woke_q  <= WOKE_RESET;
						state_q <= H_IDLE;
					end else if (link.irq_resume || link.halt_done) begin
						woke_q    <= link.irq_resume ? WOKE_IRQ : WOKE_NONE;
						state_q   <= H_CLEAR;
						wr_en_q   <= 1'b1;
						wr_sel_q  <= SEL_MCU_CONTROL;
						wr_data_q <= link.rd_ctl & 8'hDF; // R16
					end
				end
				H_CLEAR: state_q <= H_IDLE;
			endcase
			// A go landing as the old one is taken must not be lost, so the set comes last.
			if (dp_wr_q && dp_addr_q == OFS_CMD && i_hwdata[CMD_GO_BIT]) begin
				go_q <= 1'b1;
			end
		end
	end
endmodule

// [smc_if.sv]
// Link between the sleep controller and the CPU side.
// Assumes both ends run on the same clock.
interface smc_if;
	logic                 wr_en;      // Register write pulse.
	logic                 wr_sel;     // Register select.
	logic [7:0]           wr_data;    // Write data.
	logic [7:0]           rd_ctl;     // mcu_control contents.
	logic [7:0]           rd_ibd;     // input_buffer_disable contents.
	logic                 halt;       // Halt instruction pulse.
	logic                 halt_done;  // Halt completed without sleep.
	logic                 irq_resume; // Woken by interrupt, run handler.
	logic                 reset_wake; // Woken by reset, go to vector.
	logic                 asleep;     // Sleeping or waking.
	logic [3:0]           irq_idle;   // Other enabled interrupt levels.
	logic                 ext0_level; // Level interrupt on ext_irq_zero.
	logic                 pin_change; // Pin-change interrupt.
	logic                 usi_start;  // Serial start-condition interrupt.
	logic                 cmp_irq;    // Comparator interrupt.
	logic                 rst_req;    // Any reset source active.
	modport dev (
		input  wr_en, wr_sel, wr_data, halt, irq_idle, ext0_level,
		input  pin_change, usi_start, cmp_irq, rst_req,
		output rd_ctl, rd_ibd, halt_done, irq_resume, reset_wake, asleep
	);
	modport cpu (
		output wr_en, wr_sel, wr_data, halt, irq_idle, ext0_level,
		output pin_change, usi_start, cmp_irq, rst_req,
		input  rd_ctl, rd_ibd, halt_done, irq_resume, reset_wake, asleep
	);
endinterface

// [smc_pkg.sv]
// Constants, types and field layout for the sleep-mode controller.
// Assumes one 20 MHz clock and a synchronous active-high reset.
//
// Summary of operation
// [R1] Sleep needs sleep_allow set, then halt.
// [R2] Select 00 Idle, 01/11 Power-down, 10 Standby.
// [R3] Interrupt wakes; four hold cycles, then resume.
// [R4] Register file and SRAM kept across sleep.
// [R5] Reset during sleep restarts from reset vector.
// [R6] Idle stops only CPU and flash clocks.
// [R7] Idle wakes on any enabled interrupt.
// [R8] comparator_off in Idle removes comparator wake.
// [R9] Power-down stops oscillator; async detectors run.
// [R10] Power-down wakes on listed sources only.
// [R11] Power-down runs asynchronous modules only.
// [R12] Level wake source holds until recognised.
// [R13] Power-down wake delay from clock_source_fuses.
// [R14] Standby keeps oscillator; wakes in six cycles. Here osc_en is off while waking in DEV_START.
// [R15] Standby only with crystal clock source.
// [R16] Set sleep_allow before halt, clear after.
// [R17] Deep sleep disables comparator; reference may stay.
// [R18] Enabled brown-out detector stays on in sleep.
// [R19] Enabled watchdog keeps running in sleep.
// [R20] Reference on only when needed; start-up delay.
// [R21] No I/O clock: input buffers off, except wake.
// [R22] input_buffer_disable bits turn buffers off.
// [R23] Halt without sleep_allow just continues.
package smc_pkg;
	// ==========================================================
	// Device register layout.
	localparam logic       SEL_MCU_CONTROL = 1'b0;
	localparam logic       SEL_INPUT_BUF   = 1'b1;
	localparam int         BIT_SELECT_HI   = 6;
	localparam int         BIT_SLEEP_ALLOW = 5;
	localparam int         BIT_SELECT_LO   = 4;
	localparam logic [7:0] MCU_CONTROL_RST = 8'h00;
	localparam logic [7:0] INPUT_BUF_RST   = 8'h00;
	localparam logic [2:0] BOD_FUSES_OFF   = 3'h7;
	localparam logic [3:0] FUSE_EXT_CLOCK  = 4'h0;
	localparam logic [3:0] FUSE_LOW_OSC    = 4'h6;
	localparam int         IDLE_IRQ_W      = 4;
	// ==========================================================
	// Timing.
	localparam int          CLOCK_HZ       = 20_000_000;
	localparam logic [15:0] WAKE_HOLD_CYC  = 16'h0004;
	localparam logic [15:0] STANDBY_CYC    = 16'h0006;
	localparam logic [15:0] PD_EXT_CYC     = 16'h0006;
	localparam logic [15:0] PD_XTAL_CYC    = 16'h0400;
	localparam int          REF_START_NS   = 40_000;
	localparam logic [15:0] REF_START_CYC  =
		16'((REF_START_NS * (CLOCK_HZ / 1_000_000) + 999) / 1000);
	// ==========================================================
	// Host register map (word offsets on AHB-Lite).
	localparam logic [7:0] OFS_CMD     = 8'h00;
	localparam logic [7:0] OFS_STATUS  = 8'h04;
	localparam logic [7:0] OFS_WAKE    = 8'h08;
	localparam logic [7:0] OFS_IBD     = 8'h0C;
	localparam logic [7:0] OFS_DEV_CTL = 8'h10;
	localparam int         CMD_GO_BIT  = 31;
	localparam logic [1:0] WOKE_NONE   = 2'h1;
	localparam logic [1:0] WOKE_IRQ    = 2'h2;
	localparam logic [1:0] WOKE_RESET  = 2'h3;
	typedef enum logic [1:0] {
		MODE_IDLE, MODE_PDOWN, MODE_STANDBY
	} smc_mode_t;
	typedef enum {DEV_ACTIVE, DEV_SLEEP, DEV_START, DEV_HOLD} smc_dev_state_t;
	typedef enum {H_IDLE, H_ARM, H_HALT, H_WAIT, H_CLEAR} smc_host_state_t;
endpackage

// [smc_sva.sv]
// Checker for the link that joins the two ends of the sleep controller.
// Assumes the testbench hands it the link signals, the clock and the reset.
module smc_sva
	import smc_pkg::*;
(
	input wire logic       i_clock,    // System clock.
	input wire logic       i_srst,     // Synchronous reset.
	input wire logic       wr_en,      // Register write pulse.
	input wire logic [7:0] rd_ctl,     // Control register contents.
	input wire logic [7:0] rd_ibd,     // Buffer disable contents.
	input wire logic       halt,       // Halt pulse.
	input wire logic       halt_done,  // Halt finished without sleep.
	input wire logic       irq_resume, // Woken by an interrupt.
	input wire logic       reset_wake, // Woken by a reset.
	input wire logic       asleep,     // Sleeping or waking.
	input wire logic [3:0] irq_idle,   // Other interrupt levels.
	input wire logic       ext0_level, // Level interrupt zero.
	input wire logic       pin_change, // Pin-change interrupt.
	input wire logic       usi_start,  // Start-condition interrupt.
	input wire logic       rst_req     // Reset request.
);
	// ==========================================================
	// Link properties, all on the one clock.
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (i_srst);

	property p_enter;
		halt && !asleep && rd_ctl[BIT_SLEEP_ALLOW] && !rst_req |=> asleep;
	endproperty
	a_enter: assert property (p_enter) else $error("halt with sleep allowed did not sleep");

	property p_only_by_halt;
		$rose(asleep) |-> $past(halt) && $past(rd_ctl[BIT_SLEEP_ALLOW]);
	endproperty
	a_only_by_halt: assert property (p_only_by_halt) else $error("sleep began without allowed halt");

	property p_no_allow;
		halt && !asleep && !rd_ctl[BIT_SLEEP_ALLOW] && !rst_req |=> halt_done && !asleep;
	endproperty
	a_no_allow: assert property (p_no_allow) else $error("halt without allow did not complete");

	property p_idle_wake;
		asleep && !rd_ctl[BIT_SELECT_HI] && !rd_ctl[BIT_SELECT_LO] && (|irq_idle) && !rst_req
			&& !($past(asleep) && $past(irq_idle) != 4'h0) |-> ##[4:6] irq_resume;
	endproperty
	a_idle_wake: assert property (p_idle_wake) else $error("idle wake not resumed in time");

	property p_deep_source;
		irq_resume && (rd_ctl[BIT_SELECT_HI] || rd_ctl[BIT_SELECT_LO]) |-> ext0_level || pin_change || usi_start;
	endproperty
	a_deep_source: assert property (p_deep_source) else $error("deep sleep woke on wrong source");

	property p_reset_wake;
		asleep && rst_req |=> reset_wake && !asleep;
	endproperty
	a_reset_wake: assert property (p_reset_wake) else $error("reset did not end sleep");

	property p_reset_clears;
		rst_req && !wr_en |=> rd_ctl == MCU_CONTROL_RST;
	endproperty
	a_reset_clears: assert property (p_reset_clears) else $error("reset left control bits");

	property p_kept;
		asleep && !rst_req && !wr_en |=> $stable(rd_ctl) && $stable(rd_ibd);
	endproperty
	a_kept: assert property (p_kept) else $error("registers changed during sleep");

	property p_pulse;
		irq_resume || reset_wake |=> !irq_resume && !reset_wake;
	endproperty
	a_pulse: assert property (p_pulse) else $error("wake pulse longer than one cycle");
endmodule

// [test_sleep_mode_controller.sv]
// Testbench for the sleep controller: host end and device end joined by the link.
// Assumes a 20 MHz clock and drives the host over AHB-Lite as the only master.
module test_sleep_mode_controller
	import smc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================================
	// Signals and instances.
	logic        i_clock, i_srst, hsel, hwrite, hreadyout, hresp;
	logic [1:0]  htrans;
	logic [2:0]  hsize, bod_fuses;
	logic [31:0] haddr, hwdata, hrdata;
	logic [3:0]  fuses;
	logic        xtal, cmp_off, cmp_ref, wdt_en, cpu_en, flash_en, io_en, osc_en;
	logic        cmp_en, bod_en, ref_en, ref_ready, wdt_run;
	logic [7:0]  wake_mask, buf_en;
	int          n_mismatch = 0;
	int          n_checks = 0;
	int          cycles = 0;
	smc_if lk();
	smc_host smc_host_i (.i_clock(i_clock), .i_srst(i_srst), .link(lk), .i_hsel(hsel), .i_haddr(haddr),
		.i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hreadyout),
		.o_hreadyout(hreadyout), .o_hresp(hresp), .o_hrdata(hrdata));
	smc_device smc_device_i (.i_clock(i_clock), .i_srst(i_srst), .link(lk), .i_clock_source_fuses(fuses),
		.i_brownout_level_fuses(bod_fuses), .i_xtal_selected(xtal), .i_comparator_off(cmp_off),
		.i_comparator_uses_ref(cmp_ref), .i_watchdog_enable(wdt_en), .i_wake_pin_mask(wake_mask),
		.o_cpu_clk_en(cpu_en), .o_flash_clk_en(flash_en), .o_io_clk_en(io_en), .o_osc_en(osc_en),
		.o_comparator_en(cmp_en), .o_bod_en(bod_en), .o_ref_en(ref_en), .o_ref_ready(ref_ready),
		.o_watchdog_run(wdt_run), .o_input_buf_en(buf_en));
	smc_sva smc_sva_i (.i_clock(i_clock), .i_srst(i_srst), .wr_en(lk.wr_en), .rd_ctl(lk.rd_ctl),
		.rd_ibd(lk.rd_ibd), .halt(lk.halt), .halt_done(lk.halt_done), .irq_resume(lk.irq_resume),
		.reset_wake(lk.reset_wake), .asleep(lk.asleep), .irq_idle(lk.irq_idle), .ext0_level(lk.ext0_level),
		.pin_change(lk.pin_change), .usi_start(lk.usi_start), .rst_req(lk.rst_req));
	// ==========================================================
	// Clock and hang guard.
	initial begin
		i_clock = 1'b0;
		forever #25 i_clock = ~i_clock;
	end
	// A run that stalls past the ceiling is ended as a failure.
	always @(posedge i_clock) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			n_mismatch++;
			wrap_up();
		end
	end
	// ==========================================================
	// Shared tasks.
	task automatic wrap_up();
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// One single word transfer; entered just after a rising edge.
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= w;
		@(posedge i_clock);
		while (hreadyout !== 1'b1) @(posedge i_clock);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		@(posedge i_clock);
		while (hreadyout !== 1'b1) @(posedge i_clock);
		rd = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		ahb(1'b1, a, d, x);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] x;
		ahb(1'b0, a, 32'h00000000, x);
		check(x, exp);
	endtask
	// Orders a sleep and waits for the device to report it.
	task automatic enter(input logic [1:0] mode);
		int n;
		n = 0;
		wr(OFS_CMD, (32'h00000001 << CMD_GO_BIT) | {30'h00000000, mode});
		while (lk.asleep !== 1'b1 && n < 100) begin
			@(posedge i_clock);
			n++;
		end
		// Let the registered gates follow the new state before anyone looks.
		@(posedge i_clock);
		check(32'(lk.asleep), 32'h1);
	endtask
	// Raises wake levels, times the wake and checks the wake report.
	task automatic wake_up(input logic [31:0] src, input logic [1:0] woke, input int lo, input int hi);
		logic [31:0] x;
		int          n;
		n = 0;
		wr(OFS_WAKE, src);
		while (lk.irq_resume !== 1'b1 && lk.reset_wake !== 1'b1 && n < 2000) begin
			@(posedge i_clock);
			n++;
		end
		check(32'(n >= lo && n <= hi), 32'h1);
		ahb(1'b0, OFS_STATUS, 32'h00000000, x);
		while (x[0] !== 1'b0 && n < 2100) begin
			ahb(1'b0, OFS_STATUS, 32'h00000000, x);
			n++;
		end
		check(32'(x[3:2]), 32'(woke));
		ahb(1'b0, OFS_DEV_CTL, 32'h00000000, x);
		check(32'(x[BIT_SLEEP_ALLOW]), 32'h0);
		wr(OFS_WAKE, 32'h00000000);
		check(32'(cpu_en), 32'h1);
	endtask
	// ==========================================================
	// Scenarios.
	task automatic s_regs();
		rdchk(OFS_DEV_CTL, 32'(MCU_CONTROL_RST));
		check(32'({cpu_en, flash_en, io_en}), 32'h7);
		check(32'({hresp, wdt_run, bod_en}), 32'h0);
		wr(OFS_IBD, 32'h0000000F);
		wr(OFS_DEV_CTL, 32'h00000020);
		wr(8'h40, 32'hFFFFFFFF);
		rdchk(OFS_IBD, 32'h0000000F);
		check(32'(buf_en), 32'h000000F0);
		rdchk(OFS_DEV_CTL, 32'h00000000);
		rdchk(8'h40, 32'h00000000);
		wr(OFS_IBD, 32'h00000000);
	endtask
	// A reset request clears sleep_allow under the arm write, so the halt finds it zero.
	task automatic s_noallow();
		logic [31:0] x;
		int          n;
		wr(OFS_WAKE, 32'h00000100);
		wr(OFS_CMD, (32'h00000001 << CMD_GO_BIT) | 32'h00000001);
		wr(OFS_WAKE, 32'h00000000);
		n = 0;
		while (lk.halt_done !== 1'b1 && n < 10) begin
			@(posedge i_clock);
			n++;
		end
		check(32'(n >= 1 && n <= 3), 32'h1);
		check(32'(lk.asleep), 32'h0);
		ahb(1'b0, OFS_STATUS, 32'h00000000, x);
		while (x[0] !== 1'b0 && n < 20) begin
			ahb(1'b0, OFS_STATUS, 32'h00000000, x);
			n++;
		end
		check(32'(x[3:2]), 32'(WOKE_NONE));
		check(32'({cpu_en, lk.asleep}), 32'h2);
	endtask
	task automatic s_ref();
		int n;
		check(32'(ref_en), 32'h0);
		cmp_off <= 1'b0;
		cmp_ref <= 1'b1;
		n = 0;
		while (ref_ready !== 1'b1 && n < 1000) begin
			@(posedge i_clock);
			n++;
		end
		check(32'(n >= REF_START_CYC && n <= REF_START_CYC + 3), 32'h1);
		cmp_ref <= 1'b0;
		repeat (4) @(posedge i_clock);
		check(32'(ref_en), 32'h0);
	endtask
	task automatic s_idle();
		bod_fuses <= 3'h6;
		wdt_en <= 1'b1;
		enter(2'h0);
		check(32'({cpu_en, flash_en, io_en, osc_en, cmp_en}), 32'h7);
		check(32'({wdt_run, bod_en, ref_en}), 32'h7);
		wake_up(32'h00000010, WOKE_IRQ, 4, 8);
		cmp_off <= 1'b1;
		enter(2'h0);
		check(32'(cmp_en), 32'h0);
		wr(OFS_WAKE, 32'h00000008);
		repeat (20) @(posedge i_clock);
		check(32'(lk.asleep), 32'h1);
		wake_up(32'h00000018, WOKE_IRQ, 4, 8);
	endtask
	task automatic s_deep();
		wake_mask <= 8'h05;
		cmp_off <= 1'b0;
		enter(2'h1);
		check(32'({cpu_en, io_en, osc_en, cmp_en}), 32'h0);
		check(32'(buf_en), 32'h00000005);
		check(32'({wdt_run, bod_en}), 32'h3);
		wr(OFS_WAKE, 32'h000000F0);
		repeat (20) @(posedge i_clock);
		check(32'(lk.asleep), 32'h1);
		wake_up(32'h00000002, WOKE_IRQ, PD_EXT_CYC + WAKE_HOLD_CYC, PD_EXT_CYC + WAKE_HOLD_CYC + 4);
		fuses <= 4'h2;
		enter(2'h3);
		wake_up(32'h00000001, WOKE_IRQ, PD_XTAL_CYC + WAKE_HOLD_CYC, PD_XTAL_CYC + WAKE_HOLD_CYC + 4);
		xtal <= 1'b1;
		enter(2'h2);
		check(32'({io_en, osc_en}), 32'h1);
		wake_up(32'h00000004, WOKE_IRQ, STANDBY_CYC + WAKE_HOLD_CYC, STANDBY_CYC + WAKE_HOLD_CYC + 4);
		xtal <= 1'b0;
		enter(2'h2);
		check(32'(osc_en), 32'h0);
		wake_up(32'h00000100, WOKE_RESET, 0, 3);
	endtask
	// ==========================================================
	// Main sequence.
	initial begin
		i_srst = 1'b1;
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h00000000;
		fuses = 4'h0;
		bod_fuses = 3'h7;
		xtal = 1'b0;
		cmp_off = 1'b1;
		cmp_ref = 1'b0;
		wdt_en = 1'b0;
		wake_mask = 8'h00;
		repeat (2) @(posedge i_clock);
		i_srst <= 1'b0;
		@(posedge i_clock);
		s_regs();
		s_noallow();
		s_ref();
		s_idle();
		s_deep();
		wrap_up();
	end
endmodule
